/* core/mbseq_pkg.sv */
/*
 Constants, register map and state type for the motor brake sequencer.
 Assumes one 200 MHz clock with a synchronous active-high reset shared by all users.
*/
// How it works
// - sequencer runs only while control mode select equals zero, volts-per-hertz.
// - brake active only when relay or output-2 function select is 19; selects 0-19, reset 17.
// - with brake control enabled, DC braking and startup dwell are inhibited.
// - run from standstill ramps to forward or reverse release frequency per direction.
// - at release frequency, release asserts once current reaches threshold 0.0-180.0 %, default 50.0.
// - after release, frequency holds for release delay, then ramps to set frequency.
// - stop after release decelerates; at engage frequency deceleration halts and brake engage is signalled.
// - after engage, frequency holds for engage delay, then drops to zero.
// - release and engage delays accept 0.00-10.00 s, default 1.00 s.
// - release frequencies 0.00-max default 1.00 Hz; engage frequency same range, default 2.00 Hz.
package mbseq_pkg;
  // widths; frequency in 0.01 Hz, current in 0.1 %, delay in 0.01 s
  localparam int FREQ_W = 16;
  localparam int CUR_W = 11;
  localparam int TIME_W = 10;
  localparam int SEL_W = 5;
  localparam int MODE_W = 2;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int ST_W = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MODE = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_RELAY_SEL = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_OUT2_SEL = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_REL_CUR = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_REL_DLY = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_REL_FWD = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_REL_REV = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_ENG_DLY = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_ENG_FRQ = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h24;

  // values, limits and reset values
  localparam logic [MODE_W-1:0] MODE_VF = 2'h0;
  localparam logic [MODE_W-1:0] MODE_MAX = 2'h2;
  localparam logic [MODE_W-1:0] MODE_RST = 2'h1;
  localparam logic [SEL_W-1:0] SEL_BRAKE = 5'h13;
  localparam logic [SEL_W-1:0] SEL_MAX = 5'h13;
  localparam logic [SEL_W-1:0] SEL_RST = 5'h11;
  localparam logic [CUR_W-1:0] CUR_MAX = 11'h708;
  localparam logic [CUR_W-1:0] CUR_RST = 11'h1f4;
  localparam logic [TIME_W-1:0] TIME_MAX = 10'h3e8;
  localparam logic [TIME_W-1:0] TIME_RST = 10'h064;
  localparam logic [FREQ_W-1:0] REL_FRQ_RST = 16'h0064;
  localparam logic [FREQ_W-1:0] ENG_FRQ_RST = 16'h00c8;
  localparam logic [FREQ_W-1:0] FREQ_ZERO = 16'h0000;

  // status word bit positions
  localparam int STAT_RELEASE = 4;
  localparam int STAT_ENGAGED = 5;
  localparam int STAT_ENABLE = 6;
  localparam int STAT_REVERSE = 7;

  // timing: one delay unit is 10 ms
  localparam int CLK_PERIOD_NS = 5;
  localparam int DELAY_LSB_US = 10000;
  localparam int DELAY_LSB_CYC = DELAY_LSB_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [ST_W-1:0] {
    ST_STOP,
    ST_TO_REL,
    ST_WAIT_CUR,
    ST_REL_HOLD,
    ST_RUN,
    ST_TO_ENG,
    ST_ENG_HOLD
  } mbseq_state_t;
endpackage

/* core/mbseq_delay.sv */
/*
 Hold-time counter in 10 ms units for the brake sequencer.
 Assumes start is a one-cycle pulse from the same clock domain.
*/
module mbseq_delay
  import mbseq_pkg::*;
#(
  parameter int TICK_CYCLES = DELAY_LSB_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic [TIME_W-1:0] units,
  // result
  output logic done
);
  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  logic busy_r;
  logic [TIME_W-1:0] left_r;
  logic [PRE_W-1:0] pre_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      left_r <= '0;
      pre_r <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_r <= 1'b1;
        left_r <= units;
        pre_r <= '0;
      end else if (abort) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        if (left_r == '0) begin
          busy_r <= 1'b0;
          done <= 1'b1;
        end else if (pre_r == PRE_LAST) begin
          pre_r <= '0;
          left_r <= left_r - 1'b1;
        end else begin
          pre_r <= pre_r + 1'b1;
        end
      end
    end
  end
endmodule

/* core/mbseq_top.sv */
/*
 Brake sequencer core: parameter registers, brake state machine, frequency ramp.
 Assumes run and direction come from pins; set frequency and motor current
 come from drive logic on the same clock. No other drive function is modelled.
*/
module mbseq_top
  import mbseq_pkg::*;
#(
  parameter int TICK_CYCLES = DELAY_LSB_CYC,
  parameter int RAMP_CYCLES = 2000,
  parameter logic [FREQ_W-1:0] RAMP_STEP = 16'h0001,
  parameter logic [FREQ_W-1:0] MAX_FREQ = 16'h1770
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // command pins
  input wire logic run_pin,
  input wire logic reverse_pin,
  // drive side
  input wire logic [FREQ_W-1:0] set_frequency,
  input wire logic [CUR_W-1:0] motor_current,
  output logic [FREQ_W-1:0] output_frequency,
  output logic output_reverse,
  output logic dc_dwell_inhibit,
  // brake outputs
  output logic relay_brake_release,
  output logic out2_brake_release,
  output logic brake_engaged
);
  localparam int RAMP_W = $clog2(RAMP_CYCLES + 1);
  localparam logic [RAMP_W-1:0] RAMP_LAST = RAMP_W'(RAMP_CYCLES - 1);

  // parameter registers
  logic [MODE_W-1:0] control_mode_select_r;
  logic [SEL_W-1:0] relay_function_select_r;
  logic [SEL_W-1:0] output2_function_select_r;
  logic [CUR_W-1:0] release_current_threshold_r;
  logic [TIME_W-1:0] release_delay_time_r;
  logic [FREQ_W-1:0] release_forward_frequency_r;
  logic [FREQ_W-1:0] release_reverse_frequency_r;
  logic [TIME_W-1:0] engage_delay_time_r;
  logic [FREQ_W-1:0] engage_frequency_r;

  // pin synchronisers
  logic run_meta_r;
  logic run_r;
  logic rev_meta_r;
  logic rev_r;

  // sequencer state
  mbseq_state_t state_r;
  logic release_r;
  logic dir_rev_r;
  logic [FREQ_W-1:0] freq_r;
  logic [RAMP_W-1:0] ramp_cnt_r;
  logic ramp_tick;
  logic dly_start;
  logic [TIME_W-1:0] dly_units;
  logic dly_done;
  logic brake_en;
  logic [FREQ_W-1:0] freq_target;
  logic [FREQ_W-1:0] rel_freq;
  logic [FREQ_W-1:0] gap;

  always_ff @(posedge clk) begin
    if (srst) begin
      run_meta_r <= 1'b0;
      run_r <= 1'b0;
      rev_meta_r <= 1'b0;
      rev_r <= 1'b0;
    end else begin
      run_meta_r <= run_pin;
      run_r <= run_meta_r;
      rev_meta_r <= reverse_pin;
      rev_r <= rev_meta_r;
    end
  end

  // out-of-range writes are dropped, the old value stays
  always_ff @(posedge clk) begin
    if (srst) begin
      control_mode_select_r <= MODE_RST;
      relay_function_select_r <= SEL_RST;
      output2_function_select_r <= SEL_RST;
      release_current_threshold_r <= CUR_RST;
      release_delay_time_r <= TIME_RST;
      release_forward_frequency_r <= REL_FRQ_RST;
      release_reverse_frequency_r <= REL_FRQ_RST;
      engage_delay_time_r <= TIME_RST;
      engage_frequency_r <= ENG_FRQ_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_MODE: begin
          if (reg_wdata <= DATA_W'(MODE_MAX)) control_mode_select_r <= reg_wdata[MODE_W-1:0];
        end
        OFS_RELAY_SEL: begin
          if (reg_wdata <= DATA_W'(SEL_MAX)) relay_function_select_r <= reg_wdata[SEL_W-1:0];
        end
        OFS_OUT2_SEL: begin
          if (reg_wdata <= DATA_W'(SEL_MAX)) output2_function_select_r <= reg_wdata[SEL_W-1:0];
        end
        OFS_REL_CUR: begin
          if (reg_wdata <= DATA_W'(CUR_MAX)) release_current_threshold_r <= reg_wdata[CUR_W-1:0];
        end
        OFS_REL_DLY: begin
          if (reg_wdata <= DATA_W'(TIME_MAX)) release_delay_time_r <= reg_wdata[TIME_W-1:0];
        end
        OFS_REL_FWD: begin
          if (reg_wdata <= DATA_W'(MAX_FREQ)) release_forward_frequency_r <= reg_wdata[FREQ_W-1:0];
        end
        OFS_REL_REV: begin
          if (reg_wdata <= DATA_W'(MAX_FREQ)) release_reverse_frequency_r <= reg_wdata[FREQ_W-1:0];
        end
        OFS_ENG_DLY: begin
          if (reg_wdata <= DATA_W'(TIME_MAX)) engage_delay_time_r <= reg_wdata[TIME_W-1:0];
        end
        OFS_ENG_FRQ: begin
          if (reg_wdata <= DATA_W'(MAX_FREQ)) engage_frequency_r <= reg_wdata[FREQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read data valid the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_MODE: reg_rdata <= DATA_W'(control_mode_select_r);
        OFS_RELAY_SEL: reg_rdata <= DATA_W'(relay_function_select_r);
        OFS_OUT2_SEL: reg_rdata <= DATA_W'(output2_function_select_r);
        OFS_REL_CUR: reg_rdata <= DATA_W'(release_current_threshold_r);
        OFS_REL_DLY: reg_rdata <= DATA_W'(release_delay_time_r);
        OFS_REL_FWD: reg_rdata <= DATA_W'(release_forward_frequency_r);
        OFS_REL_REV: reg_rdata <= DATA_W'(release_reverse_frequency_r);
        OFS_ENG_DLY: reg_rdata <= DATA_W'(engage_delay_time_r);
        OFS_ENG_FRQ: reg_rdata <= DATA_W'(engage_frequency_r);
        OFS_STATUS: begin
          reg_rdata <= '0;
          reg_rdata[ST_W-1:0] <= state_r;
          reg_rdata[STAT_RELEASE] <= release_r;
          reg_rdata[STAT_ENGAGED] <= ~release_r;
          reg_rdata[STAT_ENABLE] <= brake_en;
          reg_rdata[STAT_REVERSE] <= dir_rev_r;
        end
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // enable needs v/f mode and at least one output on brake duty
  assign brake_en = (control_mode_select_r == MODE_VF) &&
                    ((relay_function_select_r == SEL_BRAKE) || (output2_function_select_r == SEL_BRAKE));
  assign rel_freq = dir_rev_r ? release_reverse_frequency_r : release_forward_frequency_r;

  always_comb begin
    freq_target = freq_r;
    if (!brake_en) begin
      freq_target = run_r ? set_frequency : FREQ_ZERO;
    end else begin
      case (state_r)
        ST_TO_REL: freq_target = rel_freq;
        ST_RUN: freq_target = set_frequency;
        ST_TO_ENG: freq_target = engage_frequency_r;
        default: freq_target = freq_r;
      endcase
    end
  end

  assign gap = (freq_r > freq_target) ? (freq_r - freq_target) : (freq_target - freq_r);

  always_ff @(posedge clk) begin
    if (srst) begin
      ramp_cnt_r <= '0;
    end else if (ramp_tick) begin
      ramp_cnt_r <= '0;
    end else begin
      ramp_cnt_r <= ramp_cnt_r + 1'b1;
    end
  end
  assign ramp_tick = (ramp_cnt_r == RAMP_LAST);

  // ramp generator; standstill under brake control forces zero at once
  always_ff @(posedge clk) begin
    if (srst) begin
      freq_r <= FREQ_ZERO;
    end else if (brake_en && state_r == ST_STOP) begin
      freq_r <= FREQ_ZERO;
    end else if (brake_en && state_r == ST_TO_ENG && freq_r <= engage_frequency_r) begin
      freq_r <= freq_r;
    end else if (ramp_tick && freq_r != freq_target) begin
      if (gap <= RAMP_STEP) begin
        freq_r <= freq_target;
      end else if (freq_r > freq_target) begin
        freq_r <= freq_r - RAMP_STEP;
      end else begin
        freq_r <= freq_r + RAMP_STEP;
      end
    end
  end

  // brake state machine
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_STOP;
      release_r <= 1'b0;
      dir_rev_r <= 1'b0;
    end else if (!brake_en) begin
      state_r <= ST_STOP;
      release_r <= 1'b0;
      if (freq_r == FREQ_ZERO) dir_rev_r <= rev_r;
    end else begin
      case (state_r)
        ST_STOP: begin
          release_r <= 1'b0;
          if (run_r) begin
            dir_rev_r <= rev_r;
            state_r <= ST_TO_REL;
          end
        end
        ST_TO_REL: begin
          if (!run_r) state_r <= ST_STOP;
          else if (freq_r == rel_freq) state_r <= ST_WAIT_CUR;
        end
        ST_WAIT_CUR: begin
          if (!run_r) begin
            state_r <= ST_STOP;
          end else if (motor_current >= release_current_threshold_r) begin
            release_r <= 1'b1;
            state_r <= ST_REL_HOLD;
          end
        end
        ST_REL_HOLD: begin
          if (!run_r) state_r <= ST_TO_ENG;
          else if (dly_done) state_r <= ST_RUN;
        end
        ST_RUN: begin
          if (!run_r) state_r <= ST_TO_ENG;
        end
        ST_TO_ENG: begin
          if (freq_r <= engage_frequency_r) begin
            release_r <= 1'b0;
            state_r <= ST_ENG_HOLD;
          end
        end
        ST_ENG_HOLD: begin
          if (dly_done) state_r <= ST_STOP;
        end
        default: state_r <= ST_STOP;
      endcase
    end
  end

  // hold timer launches on entry to either hold state
  always_comb begin
    dly_start = 1'b0;
    dly_units = release_delay_time_r;
    if (brake_en && state_r == ST_WAIT_CUR && run_r && motor_current >= release_current_threshold_r) begin
      dly_start = 1'b1;
    end else if (brake_en && state_r == ST_TO_ENG && freq_r <= engage_frequency_r) begin
      dly_start = 1'b1;
      dly_units = engage_delay_time_r;
    end
  end

  mbseq_delay #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_delay (
    .clk(clk),
    .srst(srst),
    .start(dly_start),
    .abort(!brake_en),
    .units(dly_units),
    .done(dly_done)
  );

  // registered outputs; release only reaches an output selected for brake duty
  always_ff @(posedge clk) begin
    if (srst) begin
      relay_brake_release <= 1'b0;
      out2_brake_release <= 1'b0;
      brake_engaged <= 1'b1;
      dc_dwell_inhibit <= 1'b0;
      output_frequency <= FREQ_ZERO;
      output_reverse <= 1'b0;
    end else begin
      relay_brake_release <= release_r && brake_en && (relay_function_select_r == SEL_BRAKE);
      out2_brake_release <= release_r && brake_en && (output2_function_select_r == SEL_BRAKE);
      brake_engaged <= !(release_r && brake_en);
      dc_dwell_inhibit <= brake_en;
      output_frequency <= freq_r;
      output_reverse <= dir_rev_r;
    end
  end
endmodule

/* tb/mbseq_props.sv */
/*
 Port assertions for the brake sequencer.
 Assumes one clock and sync reset; bound to mbseq_top below.
*/
module mbseq_props
  import mbseq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register writes
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  // outputs
  input wire logic [FREQ_W-1:0] output_frequency,
  input wire logic dc_dwell_inhibit,
  input wire logic relay_brake_release,
  input wire logic out2_brake_release,
  input wire logic brake_engaged
);
  logic [MODE_W-1:0] mode_r;
  logic [SEL_W-1:0] rsel_r;
  logic [SEL_W-1:0] osel_r;
  logic brake_en;

  // shadow of the enable terms; over-range writes are dropped as in the slave
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_r <= MODE_RST;
      rsel_r <= SEL_RST;
      osel_r <= SEL_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFS_MODE && reg_wdata <= MODE_MAX) mode_r <= reg_wdata[MODE_W-1:0];
      if (reg_addr == OFS_RELAY_SEL && reg_wdata <= SEL_MAX) rsel_r <= reg_wdata[SEL_W-1:0];
      if (reg_addr == OFS_OUT2_SEL && reg_wdata <= SEL_MAX) osel_r <= reg_wdata[SEL_W-1:0];
    end
  end
  assign brake_en = mode_r == MODE_VF && (rsel_r == SEL_BRAKE || osel_r == SEL_BRAKE);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_reset_holds_brake:
    assert property (disable iff (1'b0) srst |=> brake_engaged && !relay_brake_release && !out2_brake_release)
    else $error("brake not held after reset");
  a_off_no_release:
    assert property (!dc_dwell_inhibit ##1 !dc_dwell_inhibit |-> !relay_brake_release && !out2_brake_release)
    else $error("release while disabled");
  a_enable_follows:
    assert property ($rose(brake_en) |-> ##[0:2] dc_dwell_inhibit)
    else $error("enable not reflected");
  a_disable_follows:
    assert property ($fell(brake_en) |-> ##[0:2] !dc_dwell_inhibit)
    else $error("disable not reflected");
  a_relay_needs_sel:
    assert property ((rsel_r != SEL_BRAKE)[*3] |-> !relay_brake_release)
    else $error("relay release without select");
  a_out2_needs_sel:
    assert property ((osel_r != SEL_BRAKE)[*3] |-> !out2_brake_release)
    else $error("output 2 release without select");
  a_release_not_engaged:
    assert property (relay_brake_release || out2_brake_release |-> !brake_engaged)
    else $error("released and engaged together");
  a_release_holds_freq:
    assert property ($rose(relay_brake_release) |-> $stable(output_frequency))
    else $error("frequency moved at release");

  c_relay: cover property ($rose(relay_brake_release));
  c_out2: cover property ($rose(out2_brake_release));
  c_engage: cover property (dc_dwell_inhibit && $rose(brake_engaged));
endmodule

bind mbseq_top mbseq_props u_props (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .output_frequency(output_frequency), .dc_dwell_inhibit(dc_dwell_inhibit),
  .relay_brake_release(relay_brake_release), .out2_brake_release(out2_brake_release),
  .brake_engaged(brake_engaged)
);

/* tb/mbseq_motor_model.sv */
/*
 Motor and brake stand-in: turns the frequency command into a current.
 Assumes the bench clock; the bench sets load level and slow build-up.
*/
module mbseq_motor_model
  import mbseq_pkg::*;
(
  // drive side
  input wire logic clk,
  input wire logic [FREQ_W-1:0] output_frequency,
  input wire logic brake_release,
  output logic [CUR_W-1:0] motor_current,
  // bench controls
  input wire logic [CUR_W-1:0] load_level,
  input wire logic slow
);
  // no torque without frequency; a slow motor climbs 1.0 % a cycle
  always @(posedge clk) begin
    if (output_frequency == FREQ_ZERO)
      motor_current <= '0;
    else if (brake_release || !slow || motor_current + 11'h00a >= load_level)
      motor_current <= load_level;
    else
      motor_current <= motor_current + 11'h00a;
  end
endmodule

/* tb/mbseq_tb_top.sv */
/*
 Self-checking bench for mbseq_top with a motor model.
 Assumes short delay ticks and ramp steps set below.
*/
module mbseq_tb_top
  import mbseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 8;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic run_pin = 1'b0;
  logic reverse_pin = 1'b0;
  logic [FREQ_W-1:0] set_frequency = 16'h001e;
  logic [CUR_W-1:0] motor_current;
  logic [CUR_W-1:0] load_level = '0;
  logic [FREQ_W-1:0] output_frequency;
  logic output_reverse;
  logic dc_dwell_inhibit;
  logic relay_brake_release;
  logic out2_brake_release;
  logic brake_engaged;
  int n_fail = 0;
  int n_compared = 0;

  mbseq_top #(.TICK_CYCLES(4), .RAMP_CYCLES(2)) uut (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_pin(run_pin), .reverse_pin(reverse_pin),
    .set_frequency(set_frequency), .motor_current(motor_current), .output_frequency(output_frequency),
    .output_reverse(output_reverse), .dc_dwell_inhibit(dc_dwell_inhibit),
    .relay_brake_release(relay_brake_release), .out2_brake_release(out2_brake_release),
    .brake_engaged(brake_engaged)
  );
  mbseq_motor_model motor (
    .clk(clk), .output_frequency(output_frequency), .brake_release(!brake_engaged),
    .motor_current(motor_current), .load_level(load_level), .slow(reverse_pin)
  );

  initial forever #2.5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
  endtask
  task automatic wait_freq(input logic [FREQ_W-1:0] f);
    for (int i = 0; i < 300 && output_frequency !== f; i++) @(posedge clk);
  endtask
  task automatic wait_level(input logic v);
    for (int i = 0; i < 60 && brake_engaged !== v; i++) @(posedge clk);
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic t_defaults();
    check({brake_engaged, relay_brake_release, out2_brake_release, dc_dwell_inhibit}, 4'h8);
    rdchk(OFS_MODE, 32'h1);
    rdchk(OFS_RELAY_SEL, 32'h11);
    rdchk(OFS_OUT2_SEL, 32'h11);
    rdchk(OFS_REL_CUR, 32'h1f4);
    rdchk(OFS_REL_DLY, 32'h64);
    rdchk(OFS_ENG_DLY, 32'h64);
    rdchk(OFS_REL_FWD, 32'h64);
    rdchk(OFS_REL_REV, 32'h64);
    rdchk(OFS_ENG_FRQ, 32'hc8);
    rdchk(OFS_STATUS, 32'h20);
    rdchk(6'h3c, 32'h0);
  endtask
  // top of each range is taken, one above it is dropped
  task automatic t_limits();
    logic [ADDR_W-1:0] a [5];
    logic [DATA_W-1:0] v [5];
    a = '{OFS_MODE, OFS_OUT2_SEL, OFS_REL_CUR, OFS_REL_DLY, OFS_ENG_FRQ};
    v = '{32'h2, 32'h13, 32'h708, 32'h3e8, 32'h1770};
    for (int i = 0; i < 5; i++) begin
      wr(a[i], v[i]);
      wr(a[i], v[i] + 32'h1);
      rdchk(a[i], v[i]);
    end
  endtask
  task automatic t_disabled();
    wr(OFS_OUT2_SEL, 32'h0);
    wr(OFS_RELAY_SEL, 32'h13);
    for (int m = 1; m < 3; m++) begin
      wr(OFS_MODE, 32'(m));
      repeat (3) @(posedge clk);
      check(dc_dwell_inhibit, 1'b0);
    end
    load_level <= 11'h3ff;
    run_pin <= 1'b1;
    repeat (100) @(posedge clk);
    check({relay_brake_release, brake_engaged}, 2'h1);
    run_pin <= 1'b0;
    wait_freq(16'h0000);
    wr(OFS_REL_CUR, 32'h64);
    wr(OFS_REL_DLY, 32'h2);
    wr(OFS_ENG_DLY, 32'h2);
    wr(OFS_REL_FWD, 32'h5);
    wr(OFS_REL_REV, 32'h7);
    wr(OFS_ENG_FRQ, 32'hc);
    wr(OFS_MODE, 32'h0);
    repeat (3) @(posedge clk);
    check(dc_dwell_inhibit, 1'b1);
  endtask
  task automatic t_seq(input logic rev);
    logic [FREQ_W-1:0] f;
    f = rev ? 16'h0007 : 16'h0005;
    wr(OFS_RELAY_SEL, rev ? 32'h0 : 32'h13);
    wr(OFS_OUT2_SEL, rev ? 32'h13 : 32'h0);
    load_level <= 11'h032;
    reverse_pin <= rev;
    run_pin <= 1'b1;
    wait_freq(f);
    repeat (20) @(posedge clk);
    check({output_frequency, output_reverse}, {f, rev});
    check(relay_brake_release | out2_brake_release, 1'b0);
    load_level <= 11'h064;
    wait_level(1'b0);
    check({relay_brake_release, out2_brake_release}, {!rev, rev});
    repeat (HOLD - 1) @(posedge clk);
    check(output_frequency, f);
    wait_freq(16'h001e);
    check(output_frequency, 16'h001e);
    run_pin <= 1'b0;
    wait_level(1'b1);
    check({output_frequency, relay_brake_release, out2_brake_release}, {16'h000c, 2'h0});
    repeat (HOLD - 1) @(posedge clk);
    check(output_frequency, 16'h000c);
    wait_freq(16'h0000);
    check(output_frequency, 16'h0000);
    rdchk(OFS_STATUS, rev ? 32'he0 : 32'h60);
  endtask
  // stop before release, then switch brake control off mid-hold
  task automatic t_abort();
    wr(OFS_RELAY_SEL, 32'h13);
    load_level <= 11'h010;
    reverse_pin <= 1'b0;
    run_pin <= 1'b1;
    wait_freq(16'h0005);
    run_pin <= 1'b0;
    wait_freq(16'h0000);
    check({output_frequency, brake_engaged}, {16'h0000, 1'b1});
    load_level <= 11'h3ff;
    run_pin <= 1'b1;
    wait_level(1'b0);
    check(relay_brake_release, 1'b1);
    wr(OFS_MODE, 32'h1);
    repeat (2) @(posedge clk);
    check({relay_brake_release, brake_engaged}, 2'h1);
    run_pin <= 1'b0;
    wait_freq(16'h0000);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_defaults();
    t_limits();
    t_disabled();
    t_seq(1'b0);
    t_seq(1'b1);
    t_abort();
    end_of_test();
  end
  initial begin
    #100us;
    n_fail++;
    end_of_test();
  end
endmodule
